// ==== adc_seq_pkg.sv ====
// Shared constants and types of the mode and calibration sequencer.
package adc_seq_pkg;

    // ------------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_CONT = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_IDLE = 3'h2;
    localparam logic [2:0] MODE_PDOWN = 3'h3;
    localparam logic [2:0] MODE_ZS_INT = 3'h4;
    localparam logic [2:0] MODE_FS_INT = 3'h5;
    localparam logic [2:0] MODE_ZS_SYS = 3'h6;
    localparam logic [2:0] MODE_FS_SYS = 3'h7;
    localparam logic [2:0] MODE_RESET = MODE_CONT;

    // ------------------------------------------------------------------
    // Calibration lengths in conversion cycles and gain codes
    // ------------------------------------------------------------------
    localparam logic [2:0] CAL_CYC_SHORT = 3'h2;
    localparam logic [2:0] CAL_CYC_LONG = 3'h4;
    localparam logic [2:0] GAIN_UNITY = 3'h0;
    localparam logic [2:0] GAIN_128 = 3'h7;

    // ------------------------------------------------------------------
    // Timing: 100 MHz system clock
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int SETTLE_MS_MIN = 4;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    typedef enum logic [1:0] {
        CAL_NONE,
        CAL_ZERO,
        CAL_FULL
    } cal_kind_t;

    typedef struct packed {
        logic [3:0] rate_code;
        logic valid;
        logic [8:0] settle_ms;
        logic [15:0] rate_centihz;
    } rate_info_t;

    typedef struct packed {
        logic filter_rst;
        logic mod_rst;
        logic mod_clk_en;
        logic analog_en;
        logic clock_output_pin_en;
    } power_ctl_t;

endpackage : adc_seq_pkg

// ==== adc_mode_calibration_sequencer.sv ====
// Mode, calibration and update-rate sequencer of a sigma-delta converter.
// Behaviour
// - Mode 000 continuous default, 001 single, 010 idle.
// - Idle holds filter and modulator reset, clocks run.
// - Power-down switches off all circuitry and clock output.
// - Internal zero-scale shorts input, takes two cycles.
// - Ready high during calibration, low when done.
// - Finished calibration changes mode to idle.
// - Zero-scale result written to channel offset register.
// - Internal full-scale: two cycles unity, four other gains, refused at gain 128.
// - Full-scale result written to channel full-scale register.
// - System full-scale takes two cycles.
// - Rate codes 0000 invalid, 0001-0111 with settle times.
// - Rate codes 1000-1111 with settle times.
`timescale 1ns/10ps
`default_nettype none

module adc_mode_calibration_sequencer #(
    parameter int CHANNELS = 3,
    parameter int COEF_W = 24
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic mode_wr_i,
    input wire logic [2:0] op_mode_sel_i,
    input wire logic [3:0] update_rate_sel_i,
    input wire logic [1:0] input_channel_sel_i,
    input wire logic [2:0] gain_sel_i,
    input wire logic conv_done_i,
    input wire logic [COEF_W-1:0] conv_result_i,
    output logic [2:0] op_mode_o,
    output logic ready_n_o,
    output logic cal_busy_o,
    output logic cal_refused_o,
    output logic input_short_o,
    output logic fs_ref_apply_o,
    output adc_seq_pkg::power_ctl_t power_o,
    output adc_seq_pkg::rate_info_t rate_o,
    output logic [CHANNELS*COEF_W-1:0] offset_coef_o,
    output logic [CHANNELS*COEF_W-1:0] fullscale_coef_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Mode and calibration state
    // ------------------------------------------------------------------
    logic [2:0] mode_q, mode_d;
    adc_seq_pkg::cal_kind_t kind_q, kind_d;
    logic [2:0] left_q, left_d;
    logic [1:0] chan_q, chan_d;
    logic ready_n_q, ready_n_d;
    logic refused_q, refused_d;
    logic [COEF_W-1:0] offs_q [CHANNELS];
    logic [COEF_W-1:0] fsc_q [CHANNELS];
    logic [COEF_W-1:0] offs_d [CHANNELS];
    logic [COEF_W-1:0] fsc_d [CHANNELS];
    logic is_cal_req;

    assign is_cal_req = op_mode_sel_i[2];

    always_comb
    begin
        mode_d = mode_q;
        kind_d = kind_q;
        left_d = left_q;
        chan_d = chan_q;
        ready_n_d = ready_n_q;
        refused_d = 1'b0;
        offs_d = offs_q;
        fsc_d = fsc_q;
        if (mode_wr_i)
        begin
            if (is_cal_req && op_mode_sel_i == adc_seq_pkg::MODE_FS_INT
                && gain_sel_i == adc_seq_pkg::GAIN_128)
            begin
                // Host broke the gain limit; the request is dropped.
                refused_d = 1'b1;
            end
            else if (is_cal_req)
            begin
                mode_d = op_mode_sel_i;
                chan_d = input_channel_sel_i;
                ready_n_d = 1'b1;
                left_d = adc_seq_pkg::CAL_CYC_SHORT;
                kind_d = op_mode_sel_i[0] ? adc_seq_pkg::CAL_FULL
                                          : adc_seq_pkg::CAL_ZERO;
                if (op_mode_sel_i == adc_seq_pkg::MODE_FS_INT
                    && gain_sel_i != adc_seq_pkg::GAIN_UNITY)
                begin
                    left_d = adc_seq_pkg::CAL_CYC_LONG;
                end
            end
            else
            begin
                mode_d = op_mode_sel_i;
                kind_d = adc_seq_pkg::CAL_NONE;
                left_d = '0;
            end
        end
        else if (kind_q != adc_seq_pkg::CAL_NONE && conv_done_i)
        begin
            left_d = left_q - 3'h1;
            if (left_q == 3'h1)
            begin
                if (kind_q == adc_seq_pkg::CAL_ZERO)
                begin
                    offs_d[chan_q] = conv_result_i;
                end
                else
                begin
                    fsc_d[chan_q] = conv_result_i;
                end
                kind_d = adc_seq_pkg::CAL_NONE;
                ready_n_d = 1'b0;
                mode_d = adc_seq_pkg::MODE_IDLE;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            mode_q <= adc_seq_pkg::MODE_RESET;
            kind_q <= adc_seq_pkg::CAL_NONE;
            left_q <= '0;
            chan_q <= '0;
            ready_n_q <= 1'b1;
            refused_q <= 1'b0;
            for (int i = 0; i < CHANNELS; i++)
            begin
                offs_q[i] <= '0;
                fsc_q[i] <= '0;
            end
        end
        else
        begin
            mode_q <= mode_d;
            kind_q <= kind_d;
            left_q <= left_d;
            chan_q <= chan_d;
            ready_n_q <= ready_n_d;
            refused_q <= refused_d;
            offs_q <= offs_d;
            fsc_q <= fsc_d;
        end
    end

    // ------------------------------------------------------------------
    // Power and reset controls of the analog and filter sections
    // ------------------------------------------------------------------
    logic pdown;
    assign pdown = (mode_q == adc_seq_pkg::MODE_PDOWN);

    always_comb
    begin
        power_o.filter_rst = (mode_q == adc_seq_pkg::MODE_IDLE) || pdown;
        power_o.mod_rst = (mode_q == adc_seq_pkg::MODE_IDLE) || pdown;
        power_o.mod_clk_en = !pdown;
        power_o.analog_en = !pdown;
        power_o.clock_output_pin_en = !pdown;
    end

    assign input_short_o = (kind_q == adc_seq_pkg::CAL_ZERO)
                           && (mode_q == adc_seq_pkg::MODE_ZS_INT);
    assign fs_ref_apply_o = (kind_q == adc_seq_pkg::CAL_FULL)
                            && (mode_q == adc_seq_pkg::MODE_FS_INT);
    assign cal_busy_o = (kind_q != adc_seq_pkg::CAL_NONE);
    assign cal_refused_o = refused_q;
    assign op_mode_o = mode_q;
    assign ready_n_o = ready_n_q;

    generate
        for (genvar g = 0; g < CHANNELS; g++)
        begin : g_coef
            assign offset_coef_o[g*COEF_W +: COEF_W] = offs_q[g];
            assign fullscale_coef_o[g*COEF_W +: COEF_W] = fsc_q[g];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Update rate decode
    // ------------------------------------------------------------------
    adc_seq_pkg::rate_info_t rate_q, rate_d;

    always_comb
    begin
        rate_d.rate_code = update_rate_sel_i;
        rate_d.valid = 1'b1;
        unique case (update_rate_sel_i)
            4'h0:
            begin
                rate_d.valid = 1'b0;
                rate_d.settle_ms = 9'h000;
                rate_d.rate_centihz = 16'h0000;
            end
            4'h1:
            begin
                rate_d.settle_ms = 9'h004;
                rate_d.rate_centihz = 16'hc350;
            end
            4'h2:
            begin
                rate_d.settle_ms = 9'h008;
                rate_d.rate_centihz = 16'h61a8;
            end
            4'h3:
            begin
                rate_d.settle_ms = 9'h010;
                rate_d.rate_centihz = 16'h30d4;
            end
            4'h4:
            begin
                rate_d.settle_ms = 9'h020;
                rate_d.rate_centihz = 16'h186a;
            end
            4'h5:
            begin
                rate_d.settle_ms = 9'h028;
                rate_d.rate_centihz = 16'h1388;
            end
            4'h6:
            begin
                rate_d.settle_ms = 9'h030;
                rate_d.rate_centihz = 16'h0f50;
            end
            4'h7:
            begin
                rate_d.settle_ms = 9'h03c;
                rate_d.rate_centihz = 16'h0d02;
            end
            4'h8:
            begin
                rate_d.settle_ms = 9'h065;
                rate_d.rate_centihz = 16'h07a8;
            end
            4'h9:
            begin
                rate_d.settle_ms = 9'h078;
                rate_d.rate_centihz = 16'h0686;
            end
            4'ha:
            begin
                rate_d.settle_ms = 9'h078;
                rate_d.rate_centihz = 16'h0686;
            end
            4'hb:
            begin
                rate_d.settle_ms = 9'h0a0;
                rate_d.rate_centihz = 16'h04e2;
            end
            4'hc:
            begin
                rate_d.settle_ms = 9'h0c8;
                rate_d.rate_centihz = 16'h03e8;
            end
            4'hd:
            begin
                rate_d.settle_ms = 9'h0f0;
                rate_d.rate_centihz = 16'h0341;
            end
            4'he:
            begin
                rate_d.settle_ms = 9'h140;
                rate_d.rate_centihz = 16'h0271;
            end
            4'hf:
            begin
                rate_d.settle_ms = 9'h1e0;
                rate_d.rate_centihz = 16'h01a1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rate_q <= '0;
        end
        else
        begin
            rate_q <= rate_d;
        end
    end

    assign rate_o = rate_q;

endmodule : adc_mode_calibration_sequencer

`default_nettype wire

// ==== adc_seq_sva.sv ====
// Assertion checker of the mode and calibration sequencer.
`timescale 1ns/10ps
`default_nettype none
module adc_seq_sva (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic mode_wr_i,
    input wire logic [2:0] op_mode_sel_i,
    input wire logic [2:0] gain_sel_i,
    input wire logic conv_done_i,
    input wire logic [2:0] op_mode_o,
    input wire logic ready_n_o,
    input wire logic cal_busy_o,
    input wire logic cal_refused_o,
    input wire logic input_short_o,
    input wire logic fs_ref_apply_o,
    input wire adc_seq_pkg::power_ctl_t power_o,
    input wire adc_seq_pkg::rate_info_t rate_o
);
    logic fs128, go;
    logic [2:0] cnt_q, cnt_d, need_q, need_d;
    assign fs128 = op_mode_sel_i == adc_seq_pkg::MODE_FS_INT
        && gain_sel_i == adc_seq_pkg::GAIN_128;
    assign go = mode_wr_i && op_mode_sel_i[2] && !fs128;
    // Conversions counted since the last accepted calibration request.
    always_comb
    begin
        cnt_d = go ? 3'h0 : cnt_q + {2'h0, conv_done_i && cal_busy_o};
        need_d = need_q;
        if (go)
            need_d = (fs128 || op_mode_sel_i != adc_seq_pkg::MODE_FS_INT
                || gain_sel_i == adc_seq_pkg::GAIN_UNITY) ? 3'h2 : 3'h4;
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q <= 3'h0;
            need_q <= 3'h2;
        end
        else
        begin
            cnt_q <= cnt_d;
            need_q <= need_d;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence cal_req;
        go;
    endsequence
    sequence cal_end;
        $fell(cal_busy_o) && !$past(mode_wr_i);
    endsequence
    cal_start_a:
        assert property (cal_req |=> ready_n_o && cal_busy_o
            && op_mode_o == $past(op_mode_sel_i)) else $error("cal start");
    cal_finish_a:
        assert property (cal_end |-> !ready_n_o
            && op_mode_o == adc_seq_pkg::MODE_IDLE) else $error("cal end");
    cal_length_a:
        assert property (cal_end |-> cnt_q == need_q) else $error("cal len");
    fs_refuse_a:
        assert property (mode_wr_i && fs128 |=> cal_refused_o
            && $stable(op_mode_o)) else $error("refuse");
    ready_busy_a:
        assert property (cal_busy_o |-> ready_n_o) else $error("ready");
    input_short_a:
        assert property (input_short_o == (cal_busy_o
            && op_mode_o == adc_seq_pkg::MODE_ZS_INT)) else $error("short");
    fs_apply_a:
        assert property (fs_ref_apply_o == (cal_busy_o
            && op_mode_o == adc_seq_pkg::MODE_FS_INT)) else $error("fs in");
    idle_power_a:
        assert property (op_mode_o == adc_seq_pkg::MODE_IDLE |-> power_o.mod_rst
            && power_o.filter_rst && power_o.mod_clk_en) else $error("idle");
    pdown_power_a:
        assert property (op_mode_o == adc_seq_pkg::MODE_PDOWN |->
            !power_o.analog_en && !power_o.clock_output_pin_en) else $error("pd");
    rate_valid_a:
        assert property (rate_o.valid == (rate_o.rate_code != 4'h0))
            else $error("rate");
endmodule : adc_seq_sva
bind adc_mode_calibration_sequencer adc_seq_sva i_sva (.sys_clk_i, .nrst_i,
    .mode_wr_i, .op_mode_sel_i, .gain_sel_i, .conv_done_i, .op_mode_o,
    .ready_n_o, .cal_busy_o, .cal_refused_o, .input_short_o,
    .fs_ref_apply_o, .power_o, .rate_o);
`default_nettype wire

// ==== conv_model.sv ====
// Conversion core model that answers the sequencer with measured values.
`timescale 1ns/10ps
`default_nettype none
module conv_model (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic slow_i,
    output logic conv_done_o,
    output logic [23:0] result_o
);
    logic run_q;
    logic [3:0] tick_q, lim;
    logic [23:0] val_q;
    assign lim = slow_i ? 4'h9 : 4'h3;
    // One run sees one reference value; between results the line inverts
    // its previous value every cycle so a late sample is caught.
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            run_q <= 1'b0;
            tick_q <= 4'h0;
            val_q <= 24'h000000;
            conv_done_o <= 1'b0;
            result_o <= 24'h000000;
        end
        else
        begin
            run_q <= run_i;
            if (run_i && !run_q)
                val_q <= val_q + 24'h10a5c3;
            tick_q <= (run_i && tick_q != lim) ? tick_q + 4'h1 : 4'h0;
            conv_done_o <= run_i && tick_q == lim;
            result_o <= (run_i && tick_q == lim) ? val_q : ~result_o;
        end
    end
endmodule : conv_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench of the mode and calibration sequencer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic sys_clk_i, nrst_i, mode_wr_i, conv_done_i, slow;
    logic ready_n_o, cal_busy_o, cal_refused_o, input_short_o, fs_ref_apply_o;
    logic [2:0] op_mode_sel_i, gain_sel_i, op_mode_o;
    logic [3:0] update_rate_sel_i;
    logic [1:0] input_channel_sel_i;
    logic [23:0] conv_result_i, res;
    logic [71:0] offset_coef_o, fullscale_coef_o;
    adc_seq_pkg::power_ctl_t power_o;
    adc_seq_pkg::rate_info_t rate_o;
    int fails = 0;
    int cmp_count = 0;
    adc_mode_calibration_sequencer i_dut (.sys_clk_i, .nrst_i, .mode_wr_i,
        .op_mode_sel_i, .update_rate_sel_i, .input_channel_sel_i, .gain_sel_i,
        .conv_done_i, .conv_result_i, .op_mode_o, .ready_n_o, .cal_busy_o,
        .cal_refused_o, .input_short_o, .fs_ref_apply_o, .power_o, .rate_o,
        .offset_coef_o, .fullscale_coef_o);
    conv_model i_conv (.sys_clk_i, .nrst_i, .run_i(cal_busy_o),
        .slow_i(slow), .conv_done_o(conv_done_i), .result_o(conv_result_i));
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [2:0] m);
        @(negedge sys_clk_i) mode_wr_i = 1'b1;
        op_mode_sel_i = m;
        @(negedge sys_clk_i) mode_wr_i = 1'b0;
    endtask : wr
    task automatic t_modes();
        wr(adc_seq_pkg::MODE_SINGLE);
        chk(op_mode_o === adc_seq_pkg::MODE_SINGLE, "single");
        wr(adc_seq_pkg::MODE_IDLE);
        chk({power_o.filter_rst, power_o.mod_rst, power_o.mod_clk_en}
            === 3'h7, "idle");
        wr(adc_seq_pkg::MODE_PDOWN);
        chk({power_o.analog_en, power_o.clock_output_pin_en} === 2'h0,
            "pdown");
        wr(adc_seq_pkg::MODE_CONT);
        chk(op_mode_o === adc_seq_pkg::MODE_CONT, "cont");
    endtask : t_modes
    task automatic t_cal(input logic [2:0] m, input logic [1:0] ch,
        input logic [2:0] g, input int n);
        int k;
        k = 0;
        slow = ~slow;
        gain_sel_i = g;
        input_channel_sel_i = ch;
        wr(m);
        input_channel_sel_i = ch + 2'h1;
        chk(ready_n_o === 1'b1 && cal_busy_o === 1'b1, "start");
        chk(input_short_o === (m == adc_seq_pkg::MODE_ZS_INT)
            && fs_ref_apply_o === (m == adc_seq_pkg::MODE_FS_INT),
            "inputs");
        repeat (300)
        begin
            @(negedge sys_clk_i);
            if (conv_done_i === 1'b1)
            begin
                k++;
                res = conv_result_i;
            end
            if (cal_busy_o !== 1'b1)
                break;
        end
        chk(k == n, "length");
        chk(op_mode_o === adc_seq_pkg::MODE_IDLE && ready_n_o === 1'b0,
            "end");
        chk((m[0] ? fullscale_coef_o[ch*24 +: 24] : offset_coef_o[ch*24 +: 24])
            === res, "coef");
    endtask : t_cal
    task automatic t_refuse();
        gain_sel_i = adc_seq_pkg::GAIN_128;
        wr(adc_seq_pkg::MODE_FS_INT);
        chk(cal_refused_o === 1'b1 && op_mode_o === adc_seq_pkg::MODE_IDLE,
            "refuse");
    endtask : t_refuse
    task automatic t_rate();
        int st[16] = '{0, 4, 8, 16, 32, 40, 48, 60, 101, 120, 120, 160, 200,
            240, 320, 480};
        int hz[16] = '{0, 50000, 25000, 12500, 6250, 5000, 3920, 3330, 1960,
            1670, 1670, 1250, 1000, 833, 625, 417};
        for (int c = 0; c < 16; c++)
        begin
            update_rate_sel_i = c[3:0];
            @(negedge sys_clk_i);
            chk(rate_o.rate_code === c[3:0], "code");
            chk(rate_o.valid === (c != 0) && (c == 0 || (rate_o.settle_ms
                === st[c][8:0] && rate_o.rate_centihz === hz[c][15:0])),
                "rate");
        end
    endtask : t_rate
    task automatic t_abort();
        gain_sel_i = 3'h0;
        wr(adc_seq_pkg::MODE_ZS_INT);
        wr(adc_seq_pkg::MODE_IDLE);
        chk(cal_busy_o === 1'b0 && op_mode_o === adc_seq_pkg::MODE_IDLE,
            "abort");
        wr(adc_seq_pkg::MODE_FS_SYS);
        nrst_i = 1'b0;
        @(negedge sys_clk_i);
        chk(op_mode_o === 3'h0 && ready_n_o === 1'b1 && cal_busy_o === 1'b0
            && fullscale_coef_o === 72'h0, "mid reset");
        nrst_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        chk(op_mode_o === adc_seq_pkg::MODE_CONT, "reset release");
    endtask : t_abort
    task automatic test_done();
        $display("fails=%0d compares=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        #200000;
        fails++;
        test_done();
    end
    initial
    begin
        {nrst_i, mode_wr_i, op_mode_sel_i, gain_sel_i} = 8'h00;
        {update_rate_sel_i, input_channel_sel_i, slow, res} = 31'h0;
        repeat (5) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        chk(op_mode_o === 3'h0 && ready_n_o === 1'b1 && offset_coef_o === 72'h0,
            "reset");
        t_modes();
        t_cal(adc_seq_pkg::MODE_ZS_INT, 2'h0, 3'h0, 2);
        t_cal(adc_seq_pkg::MODE_FS_INT, 2'h1, 3'h0, 2);
        t_cal(adc_seq_pkg::MODE_FS_INT, 2'h2, 3'h3, 4);
        t_cal(adc_seq_pkg::MODE_ZS_SYS, 2'h1, 3'h0, 2);
        t_cal(adc_seq_pkg::MODE_FS_SYS, 2'h2, 3'h7, 2);
        t_refuse();
        t_rate();
        t_abort();
        test_done();
    end
endmodule : testbench
`default_nettype wire
